// [src/hexfmt_params.svh]
// constants of the hex line formatter
`ifndef HEXFMT_PARAMS_SVH
`define HEXFMT_PARAMS_SVH
`define HF_NIB_W        4
`define HF_BYTE_W       8
`define HF_ASCII_ZERO   8'h30
`define HF_ASCII_ALPHA  8'h37
`define HF_NIB_NINE     4'h9
`define HF_CR           8'h0d
`define HF_LF           8'h0a
`define HF_ZERO_BYTE    8'h00
`define HF_MOD_RST      8'h00
`define HF_SEL_PAR      4'hc
`define HF_SEL_SER      4'hd
`define HF_CLK_NS       10
`define HF_SECOND_NS    1000000000
`define HF_LAMP_NS      500000000
`define HF_SECOND_CYC   (`HF_SECOND_NS / `HF_CLK_NS)
`define HF_LAMP_CYC     (`HF_LAMP_NS / `HF_CLK_NS)
`define HF_TAIL_DATA    2'h0
`define HF_TAIL_ZERO    2'h1
`define HF_TAIL_MOD     2'h2
`endif

// [src/hexfmt_pkg.sv]
// types of the hex line formatter
package hexfmt_pkg;
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_HI   = 7'h02,
        S_LO   = 7'h04,
        S_WAIT = 7'h08,
        S_CR   = 7'h10,
        S_LF   = 7'h20,
        S_SKIP = 7'h40
    } fmt_state_t;
endpackage : hexfmt_pkg

// [src/scan_hex_line_formatter.sv]
// scan to ascii hex line formatter with serial ram buffer
// How it works
// - each byte sent as two hex characters
// - upper nibble digit first, lower second
// - tail: zero pair, modulo
// - line ends with carriage return, line feed
// - characters equal bytes times two plus six
// - position data on own line once per second
// - buffer holds characters; host reads remove them
// - character lost to a full buffer lights overflow indicator
// - selector 12 parallel, 13 serial count shown
// - serial count display tracks host draining
// - averaging divides output scan rate
// - all indicators lit briefly after power-up
// - 8-bit modulo advances by scans averaged
`timescale 1ns/10ps
`include "hexfmt_params.svh"

module scan_hex_line_formatter #(
    parameter int          BUF_DEPTH  = 16384,
    parameter int          CNT_W      = 15,
    parameter int          POS_MAX    = 128,
    parameter int unsigned SECOND_CYC = `HF_SECOND_CYC,
    parameter int unsigned LAMP_CYC   = `HF_LAMP_CYC
) (
    input  wire logic        mclk,
    input  wire logic        nrst,
    input  wire logic        scan_valid,
    input  wire logic [7:0]  scan_byte,
    input  wire logic        scan_last,
    output logic             scan_ready,
    input  wire logic        pos_valid,
    input  wire logic [7:0]  pos_byte,
    input  wire logic        pos_end,
    input  wire logic [7:0]  avg_scans,
    input  wire logic        rd_req,
    output logic             rd_valid,
    output logic [7:0]       rd_data,
    input  wire logic        ovf_clear,
    input  wire logic [3:0]  disp_sel,
    input  wire logic [15:0] par_count,
    output logic [15:0]      disp_value,
    output logic             ovf_led,
    output logic             lamp_test
);

    localparam int PW = $clog2(POS_MAX);
    localparam int AW = $clog2(BUF_DEPTH);

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        if (nib > `HF_NIB_NINE)
            hex_char = 8'({4'h0, nib}) + `HF_ASCII_ALPHA;
        else
            hex_char = 8'({4'h0, nib}) + `HF_ASCII_ZERO;
    endfunction : hex_char

    hexfmt_pkg::fmt_state_t state_q;
    logic [7:0]      cur_q;
    logic [1:0]      tail_q;
    logic            pos_mode_q;
    logic [7:0]      mod_q;
    logic [7:0]      avg_ph_q;
    logic [7:0]      avg_n;
    logic [7:0]      pos_mem [POS_MAX];
    logic [PW-1:0]   pos_wr_q;
    logic [PW-1:0]   pos_len_q;
    logic [PW-1:0]   pos_idx_q;
    logic            pos_full_q;
    logic            pos_rdy_q;
    logic [31:0]     sec_q;
    logic            pos_due_q;
    logic [7:0]      buf_mem [BUF_DEPTH];
    logic [AW-1:0]   wp_q;
    logic [AW-1:0]   rp_q;
    logic [CNT_W-1:0] cnt_q;
    logic            ovf_q;
    logic [31:0]     lamp_q;
    logic [3:0]      sel_s1_q;
    logic [3:0]      sel_s2_q;
    logic [3:0]      sel_s3_q;
    logic [3:0]      sel_q;
    logic            emit;
    logic [7:0]      emit_c;
    logic            buf_wr;
    logic            buf_rd;
    logic            buf_full;
    logic            accept;
    logic            start_pos;

    assign avg_n     = (avg_scans == 8'h00) ? 8'h01 : avg_scans;
    assign buf_full  = cnt_q == CNT_W'(BUF_DEPTH);
    assign start_pos = state_q == hexfmt_pkg::S_IDLE && pos_due_q
                       && pos_rdy_q;
    assign scan_ready = !start_pos && (state_q == hexfmt_pkg::S_IDLE
                        || state_q == hexfmt_pkg::S_WAIT
                        || state_q == hexfmt_pkg::S_SKIP);
    assign accept    = scan_valid && scan_ready;

    // character produced this cycle
    always_comb begin
        emit   = 1'b1;
        emit_c = `HF_ZERO_BYTE;
        case (state_q)
            hexfmt_pkg::S_HI: emit_c = hex_char(cur_q[7:4]);
            hexfmt_pkg::S_LO: emit_c = hex_char(cur_q[3:0]);
            hexfmt_pkg::S_CR: emit_c = `HF_CR;
            hexfmt_pkg::S_LF: emit_c = `HF_LF;
            default:          emit   = 1'b0;
        endcase
    end

    // line sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q    <= hexfmt_pkg::S_IDLE;
            cur_q      <= `HF_ZERO_BYTE;
            tail_q     <= `HF_TAIL_DATA;
            pos_mode_q <= 1'b0;
            pos_idx_q  <= '0;
        end else begin
            case (state_q)
                hexfmt_pkg::S_IDLE: begin
                    if (start_pos) begin
                        pos_mode_q <= 1'b1;
                        pos_idx_q  <= '0;
                        cur_q      <= pos_mem[0];
                        state_q    <= hexfmt_pkg::S_HI;
                    end else if (accept) begin
                        pos_mode_q <= 1'b0;
                        tail_q     <= `HF_TAIL_DATA;
                        cur_q      <= scan_byte;
                        if (avg_ph_q != 8'h00)
                            state_q <= scan_last ? hexfmt_pkg::S_IDLE
                                                 : hexfmt_pkg::S_SKIP;
                        else
                            state_q <= hexfmt_pkg::S_HI;
                    end
                end
                hexfmt_pkg::S_SKIP: begin
                    if (accept && scan_last)
                        state_q <= hexfmt_pkg::S_IDLE;
                end
                hexfmt_pkg::S_WAIT: begin
                    if (accept) begin
                        cur_q   <= scan_byte;
                        tail_q  <= scan_last ? `HF_TAIL_ZERO
                                             : `HF_TAIL_DATA;
                        state_q <= hexfmt_pkg::S_HI;
                    end
                end
                hexfmt_pkg::S_HI: state_q <= hexfmt_pkg::S_LO;
                hexfmt_pkg::S_LO: begin
                    if (pos_mode_q) begin
                        if (pos_idx_q == pos_len_q) begin
                            state_q <= hexfmt_pkg::S_CR;
                        end else begin
                            pos_idx_q <= pos_idx_q + 1'b1;
                            cur_q     <= pos_mem[pos_idx_q + 1'b1];
                            state_q   <= hexfmt_pkg::S_HI;
                        end
                    end else if (tail_q == `HF_TAIL_ZERO) begin
                        cur_q   <= `HF_ZERO_BYTE;
                        tail_q  <= `HF_TAIL_MOD;
                        state_q <= hexfmt_pkg::S_HI;
                    end else if (tail_q == `HF_TAIL_MOD) begin
                        cur_q   <= mod_q;
                        tail_q  <= `HF_TAIL_DATA;
                        pos_idx_q <= '1;
                        state_q <= hexfmt_pkg::S_HI;
                    end else if (pos_idx_q == '1) begin
                        pos_idx_q <= '0;
                        state_q <= hexfmt_pkg::S_CR;
                    end else begin
                        state_q <= hexfmt_pkg::S_WAIT;
                    end
                end
                hexfmt_pkg::S_CR: state_q <= hexfmt_pkg::S_LF;
                hexfmt_pkg::S_LF: begin
                    pos_mode_q <= 1'b0;
                    pos_idx_q  <= '0;
                    state_q    <= hexfmt_pkg::S_IDLE;
                end
                default: state_q <= hexfmt_pkg::S_IDLE;
            endcase
        end
    end

    // averaging phase and modulo count
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            avg_ph_q <= 8'h00;
            mod_q    <= `HF_MOD_RST;
        end else begin
            if (state_q == hexfmt_pkg::S_IDLE && accept && !start_pos)
                avg_ph_q <= (avg_ph_q + 8'h01 >= avg_n) ? 8'h00
                            : avg_ph_q + 8'h01;
            if (state_q == hexfmt_pkg::S_LF && !pos_mode_q)
                mod_q <= mod_q + avg_n;
        end
    end

    // position sentence capture and once-per-second release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pos_wr_q   <= '0;
            pos_len_q  <= '0;
            pos_full_q <= 1'b0;
            pos_rdy_q  <= 1'b0;
        end else if (pos_valid && !(pos_mode_q
                     && state_q != hexfmt_pkg::S_IDLE)) begin
            if (!pos_full_q) begin
                pos_mem[pos_wr_q] <= pos_byte;
                pos_full_q <= pos_wr_q == PW'(POS_MAX - 1);
                pos_wr_q   <= pos_wr_q + 1'b1;
            end
            if (pos_end) begin
                pos_len_q  <= pos_full_q ? PW'(POS_MAX - 1) : pos_wr_q;
                pos_rdy_q  <= 1'b1;
                pos_wr_q   <= '0;
                pos_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sec_q     <= 32'h0;
            pos_due_q <= 1'b0;
        end else begin
            if (sec_q == SECOND_CYC - 1) begin
                sec_q     <= 32'h0;
                pos_due_q <= 1'b1;
            end else begin
                sec_q <= sec_q + 32'h1;
                if (start_pos)
                    pos_due_q <= 1'b0;
            end
        end
    end

    // character buffer drained by host reads
    assign buf_wr = emit && !buf_full;
    assign buf_rd = rd_req && cnt_q != '0;

    always_ff @(posedge mclk) begin
        if (buf_wr)
            buf_mem[wp_q] <= emit_c;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wp_q     <= '0;
            rp_q     <= '0;
            cnt_q    <= '0;
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_valid <= buf_rd;
            if (buf_wr)
                wp_q <= (wp_q == AW'(BUF_DEPTH - 1)) ? '0 : wp_q + 1'b1;
            if (buf_rd) begin
                rd_data <= buf_mem[rp_q];
                rp_q <= (rp_q == AW'(BUF_DEPTH - 1)) ? '0 : rp_q + 1'b1;
            end
            if (buf_wr && !buf_rd)
                cnt_q <= cnt_q + 1'b1;
            else if (buf_rd && !buf_wr)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // overflow indicator: a new loss wins over a clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            ovf_q <= 1'b0;
        else if (emit && buf_full)
            ovf_q <= 1'b1;
        else if (ovf_clear)
            ovf_q <= 1'b0;
    end

    // power-up lamp test
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            lamp_q <= 32'h0;
        else if (lamp_q != LAMP_CYC)
            lamp_q <= lamp_q + 32'h1;
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lamp_test <= 1'b1;
            ovf_led   <= 1'b1;
        end else begin
            lamp_test <= lamp_q != LAMP_CYC;
            ovf_led   <= ovf_q || lamp_q != LAMP_CYC;
        end
    end

    // selector switch synchroniser and display
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sel_s1_q <= 4'h0;
            sel_s2_q <= 4'h0;
            sel_s3_q <= 4'h0;
            sel_q    <= 4'h0;
        end else begin
            sel_s1_q <= disp_sel;
            sel_s2_q <= sel_s1_q;
            sel_s3_q <= sel_s2_q;
            if (sel_s2_q == sel_s3_q)
                sel_q <= sel_s3_q;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst)
            disp_value <= 16'h0;
        else if (sel_q == `HF_SEL_SER)
            disp_value <= 16'(cnt_q);
        else if (sel_q == `HF_SEL_PAR)
            disp_value <= par_count;
        else
            disp_value <= 16'h0;
    end

    a_hi_then_lo: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_HI |=> state_q == hexfmt_pkg::S_LO
        && emit_c == hex_char($past(cur_q[3:0])))
        else $error("low digit did not follow high digit");
    a_digit_case: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_HI && cur_q[7:4] > 4'h9
        |-> emit_c >= 8'h41 && emit_c <= 8'h46)
        else $error("hex letter not upper case");
    a_digit_value: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_HI && cur_q[7:4] <= 4'h9
        |-> emit_c == 8'h30 + 8'({4'h0, cur_q[7:4]}))
        else $error("hex digit wrong");
    a_cr_lf_pair: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_CR |-> emit_c == 8'h0d
        ##1 (state_q == hexfmt_pkg::S_LF && emit_c == 8'h0a))
        else $error("line end not cr then lf");
    a_mod_step: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_LF && !pos_mode_q
        |=> mod_q == 8'($past(mod_q) + $past(avg_n)))
        else $error("modulo step wrong");
    a_ovf_sets: assert property (@(posedge mclk) disable iff (!nrst)
        emit && buf_full |=> ovf_q ##1 ovf_led)
        else $error("overflow not shown");
    a_read_drains: assert property (@(posedge mclk) disable iff (!nrst)
        buf_rd && !buf_wr |=> cnt_q == $past(cnt_q) - 1'b1 && rd_valid)
        else $error("read did not remove a byte");
    a_lamp_reset: assert property (@(posedge mclk) disable iff (!nrst)
        lamp_q < 32'd2 |-> lamp_test)
        else $error("lamp test not lit after reset");
    a_skip_silent: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_SKIP |-> !emit)
        else $error("skipped scan produced output");
    a_zero_tail: assert property (@(posedge mclk) disable iff (!nrst)
        state_q == hexfmt_pkg::S_LO && !pos_mode_q
        && tail_q == `HF_TAIL_ZERO |=> cur_q == 8'h00)
        else $error("zero pair missing before modulo");
    a_pos_second: assert property (@(posedge mclk) disable iff (!nrst)
        start_pos |-> pos_due_q && !accept)
        else $error("position line started out of turn");

endmodule : scan_hex_line_formatter

// [tb/host_reader.sv]
// host model that drains the serial character buffer
`timescale 1ns/10ps
module host_reader (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       drain_en,
    input  wire logic [3:0] pace,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data,
    output logic            rd_req
);
    logic [7:0] rx_q[$];
    logic [3:0] gap_q;

    initial begin
        rd_req = 1'b0;
        gap_q = 4'h0;
    end

    // pace gives the idle cycles between reads, so the host can stall
    always @(posedge mclk) begin
        #1;
        if (nrst !== 1'b1 || drain_en !== 1'b1) begin
            rd_req = 1'b0;
            gap_q = 4'h0;
        end else if (gap_q >= pace) begin
            rd_req = 1'b1;
            gap_q = 4'h0;
        end else begin
            rd_req = 1'b0;
            gap_q = gap_q + 4'h1;
        end
    end

    // every delivered char leaves the device buffer
    always @(posedge mclk) begin
        if (rd_valid === 1'b1)
            rx_q.push_back(rd_data);
    end
endmodule : host_reader

// [tb/scan_hex_line_formatter_tb.sv]
// testbench of the scan hex line formatter
`timescale 1ns/10ps
module scan_hex_line_formatter_tb;
    typedef struct {
        logic [7:0] nb;
        logic [7:0] base;
        logic [7:0] step;
        logic [3:0] pace;
        logic [7:0] nc;
    } row_t;

    logic        mclk, nrst, scan_valid, scan_last, scan_ready;
    logic        pos_valid, pos_end, rd_req, rd_valid, ovf_clear;
    logic        ovf_led, lamp_test, drain_en;
    logic [7:0]  scan_byte, pos_byte, avg_scans, rd_data, mod_e;
    logic [3:0]  disp_sel, pace;
    logic [15:0] par_count, disp_value;
    logic [7:0]  exp_q[$];
    int          bad_count, cmp_count, cyc;
    row_t        rows [5] = '{'{8'd10, 8'h2a, 8'h11, 4'h0, 8'd26},
                            '{8'd4, 8'h9f, 8'h10, 4'h3, 8'd14},
                            '{8'd7, 8'hf0, 8'h03, 4'h1, 8'd20},
                            '{8'd13, 8'h00, 8'h99, 4'h0, 8'd32},
                            '{8'd34, 8'h5a, 8'h01, 4'h0, 8'd74}};

    scan_hex_line_formatter #(.BUF_DEPTH(64), .SECOND_CYC(200),
                              .LAMP_CYC(20)) i_scan_hex_line_formatter (
        .mclk(mclk), .nrst(nrst), .scan_valid(scan_valid),
        .scan_byte(scan_byte), .scan_last(scan_last),
        .scan_ready(scan_ready), .pos_valid(pos_valid),
        .pos_byte(pos_byte), .pos_end(pos_end), .avg_scans(avg_scans),
        .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
        .ovf_clear(ovf_clear), .disp_sel(disp_sel),
        .par_count(par_count), .disp_value(disp_value),
        .ovf_led(ovf_led), .lamp_test(lamp_test));

    host_reader i_host_reader (
        .mclk(mclk), .nrst(nrst), .drain_en(drain_en), .pace(pace),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_req(rd_req));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            test_done;
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? {4'h3, n} : 8'h41 + {4'h0, n} - 8'h0a;
    endfunction : hexc

    task push_hex(input logic [7:0] b);
        exp_q.push_back(hexc(b[7:4]));
        exp_q.push_back(hexc(b[3:0]));
    endtask : push_hex

    task build_exp(input row_t rw, input logic [7:0] m);
        logic [7:0] b;
        b = rw.base;
        for (int i = 0; i < rw.nb; i++) begin
            push_hex(b);
            b = b + rw.step;
        end
        exp_q.push_back(8'h30);
        exp_q.push_back(8'h30);
        push_hex(m);
        exp_q.push_back(8'h0d);
        exp_q.push_back(8'h0a);
    endtask : build_exp

    task send_scan(input row_t rw);
        int t;
        for (int i = 0; i < rw.nb; i++) begin
            t = 0;
            scan_valid = 1'b1;
            scan_byte = rw.base + 8'(i) * rw.step;
            scan_last = (i == rw.nb - 1);
            // ready is settled here, before the edge that takes the byte
            while (scan_ready !== 1'b1 && t < 200) begin
                @(posedge mclk);
                #1;
                t++;
            end
            @(posedge mclk);
            #1 scan_valid = 1'b0;
            scan_last = 1'b0;
            @(posedge mclk);
            #1;
        end
    endtask : send_scan

    task check_line(input int n);
        int t;
        t = 0;
        while (i_host_reader.rx_q.size() < n && t < 3000) begin
            @(posedge mclk);
            t++;
        end
        repeat (30) @(posedge mclk);
        #1;
        chk(16'(i_host_reader.rx_q.size()), 16'(n));
        for (int i = 0; i < n && i < i_host_reader.rx_q.size(); i++)
            chk({8'h00, i_host_reader.rx_q[i]}, {8'h00, exp_q[i]});
        i_host_reader.rx_q.delete();
        exp_q.delete();
    endtask : check_line

    task send_pos(input logic [7:0] b, input logic last);
        pos_valid = 1'b1;
        pos_byte = b;
        pos_end = last;
        push_hex(b);
        @(posedge mclk);
        #1 pos_valid = 1'b0;
        pos_end = 1'b0;
        @(posedge mclk);
        #1;
    endtask : send_pos

    task show(input logic [3:0] s, input logic [15:0] v);
        disp_sel = s;
        repeat (8) @(posedge mclk);
        #1 chk(disp_value, v);
    endtask : show

    initial begin
        {nrst, scan_valid, scan_last, pos_valid, pos_end} = 5'h00;
        {ovf_clear, drain_en, scan_byte, pos_byte} = 18'h00000;
        {disp_sel, pace, mod_e, avg_scans} = 24'h000001;
        par_count = 16'h1234;
        repeat (2) @(posedge mclk);
        #1 chk(lamp_test, 16'h0001);
        chk(ovf_led, 16'h0001);
        chk({rd_valid, scan_ready}, 16'h0001);
        chk(disp_value, 16'h0000);
        nrst = 1'b1;
        repeat (5) @(posedge mclk);
        #1 chk(lamp_test, 16'h0001);
        repeat (20) @(posedge mclk);
        #1 chk({lamp_test, ovf_led}, 16'h0000);
        drain_en = 1'b1;
        for (int r = 0; r < 4; r++) begin
            pace = rows[r].pace;
            build_exp(rows[r], mod_e);
            send_scan(rows[r]);
            mod_e = mod_e + 8'h01;
            check_line(rows[r].nc);
        end
        show(4'hc, par_count);
        par_count = 16'hbeef;
        show(4'hc, 16'hbeef);
        show(4'hd, 16'h0000);
        show(4'h5, 16'h0000);
        avg_scans = 8'h02;
        for (int k = 0; k < 2; k++) begin
            build_exp(rows[1], mod_e);
            mod_e = mod_e + 8'h02;
        end
        repeat (4) send_scan(rows[1]);
        check_line(28);
        avg_scans = 8'h01;
        drain_en = 1'b0;
        build_exp(rows[4], mod_e);
        send_scan(rows[4]);
        show(4'hd, 16'd64);
        chk(ovf_led, 16'h0001);
        ovf_clear = 1'b1;
        @(posedge mclk);
        #1 ovf_clear = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(ovf_led, 16'h0000);
        drain_en = 1'b1;
        check_line(64);
        show(4'hd, 16'h0000);
        send_pos(8'h24, 1'b0);
        send_pos(8'h47, 1'b0);
        send_pos(8'h50, 1'b1);
        exp_q.push_back(8'h0d);
        exp_q.push_back(8'h0a);
        check_line(8);
        test_done;
    end
endmodule : scan_hex_line_formatter_tb
